/* logic/io_port_pkg.sv */
package io_port_pkg;
   // =========================================================
   // register map (low 16 bits of the address)
   localparam logic [15:0] ADDR_DIR_SELECT = 16'hFFD0;
   localparam logic [15:0] ADDR_OUT_LATCH = 16'hFFD2;
   localparam logic [7:0] DIR_RESET = 8'hC0;
   localparam logic [7:0] LATCH_RESET = 8'hC0;
   localparam logic [7:0] RESERVED_ONES = 8'hC0;
   localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // =========================================================
   // pin positions within the port
   localparam int PIN_TXD0 = 0;
   localparam int PIN_TXD1 = 1;
   localparam int PIN_RXD0 = 2;
   localparam int PIN_RXD1 = 3;
   localparam int PIN_SCK0 = 4;
   localparam int PIN_SCK1 = 5;
   localparam int PORT_WIDTH = 6;

   // per-channel serial request toward the pins
   typedef struct packed {
      logic tx_en;   // transmitter owns its pin
      logic tx_data;
      logic rx_en;   // receiver owns its pin
      logic sck_out_en; // channel drives the serial clock
      logic sck_out;
      logic sck_in_en;  // channel takes an external clock
   } serial_req_t;

   // everything the port remembers
   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] latch;
      logic [7:0] rdata;
      logic [5:0] pin_out;
      logic [5:0] pin_oe;
      logic [1:0] rxd;
      logic [1:0] sck_in;
      logic [1:0] irq;
   } port_state_t;
endpackage : io_port_pkg

/* logic/six_bit_io_port.sv */
`timescale 1ns/1ps
// Summary of operation
// - six pins, each usable as general input or output in all modes
// - pin function selection ignores the chip operating mode
// - pins shared with transmit, receive and clock of serial channels 0, 1
// - two pins feed external interrupts when enabled, regardless of direction
// - direction register at FFD0, write only, resets to C0
// - output latch at FFD2, read and write, resets to C0
// - top two direction bits reserved, writes ignored, read as one
// - direction bit one drives the pin, zero makes it an input
// - reading the direction register returns all ones
// - reset and hardware standby load direction with C0
// - software standby keeps direction and keeps outputs driven
// - port read gives latch for outputs, pin level for inputs
// - latch resets to C0 in reset and hardware standby, kept otherwise
module six_bit_io_port
   import io_port_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_hw_standby,
   input wire logic i_sw_standby,
   input wire logic [1:0] i_irq_enable,
   input wire serial_req_t i_serial_zero,
   input wire serial_req_t i_serial_one,
   input wire logic [5:0] i_pin,
   output logic [5:0] o_pin,
   output logic [5:0] o_pin_oe,
   output logic [1:0] o_serial_rxd,
   output logic [1:0] o_serial_sck_in,
   output logic [1:0] o_external_interrupt
);
   // =========================================================
   // state
   port_state_t state;
   port_state_t next_state;
   logic [5:0] next_out;
   logic [5:0] next_oe;
   serial_req_t ch [2];

   // =========================================================
   // pin map and ownership
   // pin 0 carries transmit data of serial channel zero
   // pin 1 carries transmit data of serial channel one
   // pin 2 carries receive data of serial channel zero
   // pin 3 carries receive data of serial channel one
   // pin 4 carries the serial clock of channel zero and interrupt four
   // pin 5 carries the serial clock of channel one and interrupt five
   // a pin not claimed by its serial channel is plain general I/O
   // general I/O follows the direction bit and the output latch
   // a claimed pin ignores its direction bit while the claim stands
   // the receive claim only releases the pad, it never drives it
   // a clock claim either drives the pad or releases it for input
   // driving the clock wins when both clock requests are raised
   // interrupt pins read the pad level whatever drives the pad
   // so an output pin can raise its own interrupt by design
   // the interrupt output is the raw pad level gated by its enable
   // no polarity or edge detection is done here; the controller does it
   // receive and clock inputs are sampled every cycle, no filtering
   // software must not expect glitch rejection from this block
   // hardware standby releases every pad, serial claims included
   // software standby freezes both registers but not the pads
   // a serial channel may still toggle its pins in software standby
   // that is the channel's own business; it gates its own requests
   // =========================================================
   // register access notes
   // only the low sixteen address bits reach this block
   // reads of other addresses return zero and have no side effect
   // read data stand for one cycle only, then fall back to zero
   // direction reads return all ones; the stored value is hidden
   // writes in either standby are dropped without any answer

   assign ch[0] = i_serial_zero;
   assign ch[1] = i_serial_one;

   // =========================================================
   // pin multiplexing; serial functions take priority over general I/O
   always_comb begin
      // general I/O first, no mode input exists to alter it
      next_out = state.latch[5:0];
      next_oe = state.dir[5:0];
      for (int c = 0; c < 2; c++) begin
         // transmit pins
         if (ch[c].tx_en) begin
            next_out[PIN_TXD0 + c] = ch[c].tx_data;
            next_oe[PIN_TXD0 + c] = 1'b1;
         end
         if (ch[c].rx_en) begin
            next_oe[PIN_RXD0 + c] = 1'b0;
         end
         if (ch[c].sck_out_en) begin
            next_out[PIN_SCK0 + c] = ch[c].sck_out;
            next_oe[PIN_SCK0 + c] = 1'b1;
         end else if (ch[c].sck_in_en) begin
            next_oe[PIN_SCK0 + c] = 1'b0;
         end
      end
   end

   // =========================================================
   // register file and pin sampling
   always_comb begin
      next_state = state;
      next_state.pin_out = next_out;
      next_state.pin_oe = next_oe; // held through soft standby
      next_state.rxd = {i_pin[PIN_RXD1], i_pin[PIN_RXD0]};
      next_state.sck_in = {i_pin[PIN_SCK1], i_pin[PIN_SCK0]};
      // interrupt pins read the pad whatever the direction
      next_state.irq = i_irq_enable &
                       {i_pin[PIN_SCK1], i_pin[PIN_SCK0]};
      next_state.rdata = UNMAPPED_READ;
      if (i_wr && !i_sw_standby) begin
         if (i_addr == ADDR_DIR_SELECT) begin
            next_state.dir = i_wdata | RESERVED_ONES;
         end else if (i_addr == ADDR_OUT_LATCH) begin
            next_state.latch = i_wdata | RESERVED_ONES;
         end
      end
      if (i_rd) begin
         if (i_addr == ADDR_DIR_SELECT) begin
            next_state.rdata = DIR_READ_VALUE;
         end else if (i_addr == ADDR_OUT_LATCH) begin
            next_state.rdata = RESERVED_ONES |
               {2'b00, (state.dir[5:0] & state.latch[5:0]) |
                       (~state.dir[5:0] & i_pin)};
         end
      end
      // hardware standby behaves like reset for both registers
      if (i_hw_standby) begin
         next_state.dir = DIR_RESET;
         next_state.latch = LATCH_RESET;
         next_state.pin_oe = 6'h00;
      end
   end

   // register the whole state
   // reset loads constants only; the register file then starts from a
   // known map, so reads in the first cycle after release are defined.
   // pads come out of reset released, which keeps the board safe while
   // software has not yet chosen the directions.
   // the reserved direction and latch bits are set here and kept by
   // every write, so they can never read back as zero.
   // pin outputs lag the registers by one cycle: a write at one edge
   // shows on the pads at the next edge after that.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state <= '0;
         state.dir <= DIR_RESET;
         state.latch <= LATCH_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign o_rdata = state.rdata;
   assign o_pin = state.pin_out;
   assign o_pin_oe = state.pin_oe;
   assign o_serial_rxd = state.rxd;
   assign o_serial_sck_in = state.sck_in;
   assign o_external_interrupt = state.irq;

   // =========================================================
   // checks
   chk_dir_read_ones: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_rd && i_addr == ADDR_DIR_SELECT |=> o_rdata == 8'hFF)
      else $error("direction read not all ones");
   chk_dir_reserved_set: assert property (@(posedge i_clk_sys)
      disable iff (i_reset) state.dir[7:6] == 2'b11)
      else $error("direction reserved bits lost");
   chk_latch_reserved: assert property (@(posedge i_clk_sys)
      disable iff (i_reset) state.latch[7:6] == 2'b11)
      else $error("latch reserved bits lost");
   chk_hw_standby_dir: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_hw_standby |=> state.dir == 8'hC0 && state.latch == 8'hC0)
      else $error("hardware standby did not reload");
   chk_latch_write: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_wr && !i_sw_standby && !i_hw_standby && i_addr == ADDR_OUT_LATCH
      |=> state.latch[5:0] == $past(i_wdata[5:0]))
      else $error("latch write lost");
   chk_port_read: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_rd && i_addr == ADDR_OUT_LATCH |=> o_rdata ==
      (8'hC0 | {2'b00, ($past(state.dir[5:0]) & $past(state.latch[5:0]))
      | (~$past(state.dir[5:0]) & $past(i_pin))}))
      else $error("port read mixes wrong sources");
   chk_gpio_drive: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      !i_hw_standby && i_serial_zero == '0 && i_serial_one == '0
      |=> o_pin_oe == $past(state.dir[5:0]) &&
          o_pin == $past(state.latch[5:0]))
      else $error("general output not driven from latch");
   chk_sw_standby_hold: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_sw_standby && !i_hw_standby |=> $stable(state.dir))
      else $error("direction changed in software standby");
   chk_irq_route: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_irq_enable[0] |=> o_external_interrupt[0] == $past(i_pin[PIN_SCK0]))
      else $error("interrupt input not routed");
   chk_tx_share: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_serial_zero.tx_en && !i_hw_standby |=> o_pin_oe[PIN_TXD0] &&
      o_pin[PIN_TXD0] == $past(i_serial_zero.tx_data))
      else $error("transmit pin not taken by serial channel");

   // =========================================================
   // further checks on sharing, sampling and register holding
   // channel one transmit owns pin 1
   chk_tx_one_share: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_serial_one.tx_en && !i_hw_standby
      |=> o_pin_oe[PIN_TXD1] &&
          o_pin[PIN_TXD1] == $past(i_serial_one.tx_data))
      else $error("channel one transmit pin not taken");
   // receive claim releases pin 2
   chk_rx_zero_release: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_serial_zero.rx_en
      |=> !o_pin_oe[PIN_RXD0])
      else $error("channel zero receive pin still driven");
   // receive claim releases pin 3
   chk_rx_one_release: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_serial_one.rx_en
      |=> !o_pin_oe[PIN_RXD1])
      else $error("channel one receive pin still driven");
   // clock output claim drives pin 5
   chk_sck_out_drive: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_serial_one.sck_out_en && !i_hw_standby
      |=> o_pin_oe[PIN_SCK1] &&
          o_pin[PIN_SCK1] == $past(i_serial_one.sck_out))
      else $error("serial clock output not driven");
   // clock input claim releases pin 4
   chk_sck_in_release: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_serial_zero.sck_in_en && !i_serial_zero.sck_out_en
      |=> !o_pin_oe[PIN_SCK0])
      else $error("serial clock input pin still driven");
   // receive data follow the pads a cycle later
   chk_rxd_sample: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      1'b1
      |=> o_serial_rxd[0] == $past(i_pin[PIN_RXD0]) &&
          o_serial_rxd[1] == $past(i_pin[PIN_RXD1]))
      else $error("receive data not sampled from pads");
   // clock inputs follow the pads a cycle later
   chk_sck_sample: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      1'b1
      |=> o_serial_sck_in[0] == $past(i_pin[PIN_SCK0]) &&
          o_serial_sck_in[1] == $past(i_pin[PIN_SCK1]))
      else $error("serial clock not sampled from pads");
   // interrupt five follows pin 5 when enabled
   chk_irq_five_route: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_irq_enable[1]
      |=> o_external_interrupt[1] == $past(i_pin[PIN_SCK1]))
      else $error("interrupt five not routed");
   // a disabled interrupt four stays quiet
   chk_irq_masked: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      !i_irq_enable[0]
      |=> !o_external_interrupt[0])
      else $error("disabled interrupt raised");
   // direction write lands in the low six bits
   chk_dir_write: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_wr && !i_sw_standby && !i_hw_standby && i_addr == ADDR_DIR_SELECT
      |=> state.dir[5:0] == $past(i_wdata[5:0]))
      else $error("direction write lost");
   // software standby keeps the latch
   chk_sw_standby_latch: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_sw_standby && !i_hw_standby
      |=> $stable(state.latch))
      else $error("latch changed in software standby");
   // software standby keeps general outputs driven
   chk_sw_standby_pins: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_sw_standby && !i_hw_standby &&
      i_serial_zero == '0 && i_serial_one == '0
      |=> o_pin_oe == $past(state.dir[5:0]))
      else $error("output released in software standby");
   // hardware standby releases every pad
   chk_hw_standby_oe: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_hw_standby
      |=> o_pin_oe == 6'h00)
      else $error("pad driven in hardware standby");
   // read data fall back to zero when no read was made
   chk_rdata_idle: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      !i_rd
      |=> o_rdata == UNMAPPED_READ)
      else $error("read data not idle");
   // direction holds without a write
   chk_dir_hold: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      !i_wr && !i_hw_standby
      |=> $stable(state.dir))
      else $error("direction changed without a write");
   // latch holds without a write
   chk_latch_hold: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      !i_wr && !i_hw_standby
      |=> $stable(state.latch))
      else $error("latch changed without a write");
endmodule : six_bit_io_port

/* bench/pad_partner.sv */
`timescale 1ns/1ps
// =========================================================
// pad model: what the outside world shows on the six pins
module pad_partner (
   input wire logic [5:0] i_drive,
   input wire logic [5:0] i_drive_oe,
   input wire logic [5:0] i_ext,
   output logic [5:0] o_level
);
   // an undriven pad shows the outside level, never the stale port value
   assign o_level = (i_drive_oe & i_drive) | (~i_drive_oe & i_ext);
endmodule : pad_partner

/* bench/six_bit_io_port_tb_top.sv */
`timescale 1ns/1ps
module six_bit_io_port_tb_top;
   import io_port_pkg::*;
   logic clk_sys, reset, wr, rd, hw_sb, sw_sb;
   logic [15:0] addr;
   logic [7:0] wdata, rdata;
   logic [1:0] irq_en, rxd, sck_in, ext_irq;
   serial_req_t ser0, ser1;
   logic [5:0] ext, pin_level, pin_out, pin_oe;
   int mismatches, tests_run;
   // =========================================================
   // clock, design and pads
   always #5 clk_sys = ~clk_sys;
   six_bit_io_port u_six_bit_io_port (.i_clk_sys(clk_sys), .i_reset(reset),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_hw_standby(hw_sb), .i_sw_standby(sw_sb), .i_irq_enable(irq_en),
      .i_serial_zero(ser0), .i_serial_one(ser1), .i_pin(pin_level),
      .o_pin(pin_out), .o_pin_oe(pin_oe), .o_serial_rxd(rxd),
      .o_serial_sck_in(sck_in), .o_external_interrupt(ext_irq));
   pad_partner u_pad_partner (.i_drive(pin_out), .i_drive_oe(pin_oe),
      .i_ext(ext), .o_level(pin_level));
   // =========================================================
   // shared tasks
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stand only in the cycle after the strobe, so look there
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp,
                         input string what);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 check(what, rdata, exp);
   endtask : rd_chk
   // pins follow the registers a cycle later; wait past that
   task automatic settle;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : settle
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // =========================================================
   // tests
   initial begin
      {clk_sys, wr, rd, hw_sb, sw_sb, irq_en, wdata} = '0;
      {ser0, ser1} = '0;
      addr = 16'h0000;
      ext = 6'h15;
      reset = 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      settle;
      check("oe after reset", {2'b00, pin_oe}, 8'h00);
      rd_chk(ADDR_DIR_SELECT, 8'hFF, "dir read");
      rd_chk(ADDR_OUT_LATCH, 8'hD5, "latch reset");
      rd_chk(16'hFFD4, 8'h00, "unmapped read");
      $display("test reset done");
      wr_reg(ADDR_DIR_SELECT, 8'h0F);
      wr_reg(ADDR_OUT_LATCH, 8'h2A);
      settle;
      check("oe", {2'b00, pin_oe}, 8'h0F);
      check("pin out", {2'b00, pin_out & pin_oe}, 8'h0A);
      rd_chk(ADDR_OUT_LATCH, 8'hDA, "mixed read");
      rd_chk(ADDR_DIR_SELECT, 8'hFF, "dir read back");
      @(posedge clk_sys);
      sw_sb <= 1'b1;
      wr_reg(ADDR_DIR_SELECT, 8'h00);
      settle;
      check("oe standby", {2'b00, pin_oe}, 8'h0F);
      check("pin standby", {2'b00, pin_out & pin_oe}, 8'h0A);
      @(posedge clk_sys);
      sw_sb <= 1'b0;
      $display("test output done");
      @(posedge clk_sys);
      irq_en <= 2'b11;
      settle;
      check("irq input", {6'h00, ext_irq}, 8'h01);
      wr_reg(ADDR_DIR_SELECT, 8'h2F);
      settle;
      check("irq output", {6'h00, ext_irq}, 8'h03);
      rd_chk(ADDR_OUT_LATCH, 8'hFA, "read with irq");
      @(posedge clk_sys);
      ser0.tx_en <= 1'b1;
      ser0.tx_data <= 1'b1;
      settle;
      check("tx pin", {6'h00, pin_oe[0], pin_out[0]}, 8'h03);
      @(posedge clk_sys);
      ser1.rx_en <= 1'b1;
      ser1.sck_out_en <= 1'b1;
      ser1.sck_out <= 1'b0;
      settle;
      check("rx pin oe", {7'h00, pin_oe[3]}, 8'h00);
      check("sck out", {6'h00, pin_oe[5], pin_out[5]}, 8'h02);
      check("rxd in", {6'h00, rxd}, 8'h00);
      check("sck in", {6'h00, sck_in}, 8'h01);
      check("irq on sck", {6'h00, ext_irq}, 8'h01);
      $display("test shared done");
      @(posedge clk_sys);
      hw_sb <= 1'b1;
      settle;
      check("oe hw standby", {2'b00, pin_oe}, 8'h00);
      @(posedge clk_sys);
      hw_sb <= 1'b0;
      {ser0, ser1} <= '0;
      settle;
      check("oe after hw", {2'b00, pin_oe}, 8'h00);
      rd_chk(ADDR_OUT_LATCH, 8'hD5, "latch after hw");
      $display("test standby done");
      tally_and_finish;
   end
   // watchdog: the tests need well under a hundred cycles
   initial begin
      repeat (2000) @(posedge clk_sys);
      mismatches++;
      tally_and_finish;
   end
endmodule : six_bit_io_port_tb_top
